// file: src/branch_skip_unary_alu_exec.sv
`timescale 1ns/1ns
`include "alu_exec_defines.svh"
// Summary of operation
// - Set-bits ORs register with mask, updates Z N V S, one cycle.
// - Clear-bits ANDs register with inverted mask, updates Z N V S, one cycle.
// - Test ANDs register with itself, flags show zero or negative, one cycle.
// - Pointer jump loads PC from Z, upper bits zero, two cycles.
// - Pointer call jumps to Z, pushes return address, three or four cycles.
// - Compare-skip skips next instruction when registers equal, 1/2/3 cycles.
// - Skip when selected register bit is zero, 1/2/3 cycles.
// - Skip when selected register bit is one, flags untouched.
// - Skip when selected I/O bit is zero, PC advances 1, 2 or 3.
// - Skip when selected I/O bit is one, 1/2/3 cycles.
// - Branch when selected status bit set, PC plus offset plus one.
// - Branch when selected status bit clear, one or two cycles.
// - Carry-clear and same-or-higher branches both test carry zero.
// - Signed not-less branch taken when N xor V is zero.
// - Signed less branch taken when N xor V is one.
// - Half-carry-set branch taken when H is one, one or two cycles.
module branch_skip_unary_alu_exec
   import alu_exec_pkg::*;
#(
   parameter int PC_W = 22,
   parameter int STACK_D = 8,
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   localparam int SP_W = $clog2(STACK_D);

   logic aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt;
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_r, bvalid_nxt, ar_rdy_r, ar_rdy_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   op_e op_r, op_nxt;
   logic go_r, go_nxt, busy_r, busy_nxt, taken_r, taken_nxt;
   logic [2:0] cnt_r, cnt_nxt, cyc_r, cyc_nxt;
   logic [31:0] opnd_r, opnd_nxt;
   logic [11:0] offs_r, offs_nxt;
   logic [15:0] zptr_r, zptr_nxt;
   logic [8:0] iov_r, iov_nxt;
   logic [PC_W-1:0] pc_r, pc_nxt, ppc_r, ppc_nxt;
   logic [7:0] flags_r, flags_nxt, pfl_r, pfl_nxt;
   logic [7:0] res_r, res_nxt, pres_r, pres_nxt;
   logic push_r, push_nxt, pop_r, pop_nxt;
   logic [SP_W-1:0] sp_r, sp_nxt;
   logic [PC_W-1:0] stack_r [STACK_D];

   logic wr_go, commit;
   logic [31:0] wmerged;
   logic [7:0] e_res, e_fl;
   logic [PC_W-1:0] e_pc, k_short, k_long, pc_inc;
   logic [2:0] e_cyc;
   logic e_hit, e_alu, e_br, e_skip;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[8*i +: 8] = d[8*i +: 8];
         end
      end
      return m;
   endfunction

   assign awready = aw_rdy_r;
   assign wready = w_rdy_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = ar_rdy_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;

   assign wr_go = aw_got_r && w_got_r && !bvalid_r;
   assign commit = busy_r && (cnt_r == `CYC_ONE);
   assign k_short = PC_W'($signed(offs_r[`SHORT_OFFS_W-1:0]));
   assign k_long = PC_W'($signed(offs_r));
   assign pc_inc = pc_r + PC_W'(1);

   // Instruction evaluation; results are held until the last cycle.
   always_comb begin
      logic [7:0] rd, msk;
      logic [2:0] bs;
      logic two;
      rd = opnd_r[7:0];
      msk = opnd_r[15:8];
      bs = opnd_r[18:16];
      two = iov_r[`IOV_TWO_WORD];
      e_res = rd;
      e_fl = flags_r;
      e_pc = pc_inc;
      e_cyc = `CYC_ONE;
      e_hit = 1'b0;
      e_alu = 1'b0;
      e_br = 1'b0;
      e_skip = 1'b0;
      case (op_r)
         ones_complement_op: begin
            e_res = `BYTE_FF - rd;
            e_alu = 1'b1;
            e_fl[`FLG_C] = 1'b1;
         end
         twos_complement_op: begin
            e_res = `BYTE_00 - rd;
            e_alu = 1'b1;
            e_fl[`FLG_C] = (e_res != `BYTE_00);
            e_fl[`FLG_H] = e_res[3] | rd[3];
         end
         set_bits_mask_op: begin
            e_res = rd | msk;
            e_alu = 1'b1;
         end
         clear_bits_mask_op: begin
            e_res = rd & ~msk;
            e_alu = 1'b1;
         end
         zero_minus_test_op: begin
            e_res = rd & rd;
            e_alu = 1'b1;
         end
         relative_jump_op: begin
            e_pc = pc_inc + k_long;
            e_cyc = `CYC_TWO;
         end
         pointer_jump_op: begin
            e_pc = PC_W'(zptr_r);
            e_cyc = `CYC_TWO;
         end
         pointer_call_op: begin
            e_pc = PC_W'(zptr_r);
            e_cyc = (PC_W > `SHORT_PC_W) ? `CYC_FOUR : `CYC_THREE;
         end
         interrupt_return_op: begin
            e_pc = stack_r[sp_r - SP_W'(1)];
            e_fl[`FLG_I] = 1'b1;
            e_cyc = (PC_W > `SHORT_PC_W) ? `CYC_FIVE : `CYC_FOUR;
         end
         compare_skip_equal_op: begin
            e_hit = (rd == msk);
            e_skip = 1'b1;
         end
         skip_reg_bit_clear_op: begin
            e_hit = !rd[bs];
            e_skip = 1'b1;
         end
         skip_reg_bit_set_op: begin
            e_hit = rd[bs];
            e_skip = 1'b1;
         end
         skip_io_bit_clear_op: begin
            e_hit = !iov_r[bs];
            e_skip = 1'b1;
         end
         skip_io_bit_set_op: begin
            e_hit = iov_r[bs];
            e_skip = 1'b1;
         end
         branch_status_bit_set_op: begin
            e_hit = flags_r[bs];
            e_br = 1'b1;
         end
         branch_status_bit_clear_op: begin
            e_hit = !flags_r[bs];
            e_br = 1'b1;
         end
         branch_carry_clear_op, branch_same_higher_op: begin
            e_hit = !flags_r[`FLG_C];
            e_br = 1'b1;
         end
         branch_signed_not_less_op: begin
            e_hit = !(flags_r[`FLG_N] ^ flags_r[`FLG_V]);
            e_br = 1'b1;
         end
         branch_signed_less_op: begin
            e_hit = flags_r[`FLG_N] ^ flags_r[`FLG_V];
            e_br = 1'b1;
         end
         branch_half_carry_set_op: begin
            e_hit = flags_r[`FLG_H];
            e_br = 1'b1;
         end
         default: begin
            e_pc = pc_inc;
         end
      endcase
      if (e_alu) begin
         e_fl[`FLG_Z] = (e_res == `BYTE_00);
         e_fl[`FLG_N] = e_res[7];
         e_fl[`FLG_V] = (op_r == twos_complement_op) ?
                        (e_res == `BYTE_MIN) : 1'b0;
         e_fl[`FLG_S] = e_fl[`FLG_N] ^ e_fl[`FLG_V];
      end
      // A skipped two-word instruction costs one more cycle and word.
      if (e_skip && e_hit) begin
         e_pc = two ? pc_inc + PC_W'(2) : pc_inc + PC_W'(1);
         e_cyc = two ? `CYC_THREE : `CYC_TWO;
      end
      if (e_br && e_hit) begin
         e_pc = pc_inc + k_short;
         e_cyc = `CYC_TWO;
      end
   end

   always_comb begin
      aw_rdy_nxt = aw_rdy_r;
      w_rdy_nxt = w_rdy_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      ar_rdy_nxt = ar_rdy_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (awvalid && aw_rdy_r) begin
         aw_rdy_nxt = 1'b0;
         aw_got_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && w_rdy_r) begin
         w_rdy_nxt = 1'b0;
         w_got_nxt = 1'b1;
         w_data_nxt = wdata;
         w_strb_nxt = wstrb;
      end
      if (wr_go) begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (aw_addr_r > `ADDR_STAT) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
         aw_rdy_nxt = 1'b1;
         w_rdy_nxt = 1'b1;
      end
      if (arvalid && ar_rdy_r) begin
         ar_rdy_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = `RESP_OKAY;
         case (araddr)
            `ADDR_CTRL: rdata_nxt = {27'h000_0000, op_r};
            `ADDR_OPND: rdata_nxt = opnd_r;
            `ADDR_OFFS: rdata_nxt = {20'h0_0000, offs_r};
            `ADDR_ZPTR: rdata_nxt = {16'h0000, zptr_r};
            `ADDR_IOV: rdata_nxt = {23'h00_0000, iov_r};
            `ADDR_PC: rdata_nxt = 32'(pc_r);
            `ADDR_FLAGS: rdata_nxt = {24'h00_0000, flags_r};
            `ADDR_STAT: rdata_nxt = {8'h00, 8'(sp_r), res_r,
                                     3'h0, cyc_r, taken_r, busy_r};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = `RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
         ar_rdy_nxt = 1'b1;
      end
   end

   assign wmerged = merge(32'h0000_0000, w_data_r, w_strb_r);

   always_comb begin
      op_nxt = op_r;
      go_nxt = 1'b0;
      opnd_nxt = opnd_r;
      offs_nxt = offs_r;
      zptr_nxt = zptr_r;
      iov_nxt = iov_r;
      pc_nxt = pc_r;
      flags_nxt = flags_r;
      busy_nxt = busy_r;
      cnt_nxt = cnt_r;
      cyc_nxt = cyc_r;
      taken_nxt = taken_r;
      res_nxt = res_r;
      ppc_nxt = ppc_r;
      pfl_nxt = pfl_r;
      pres_nxt = pres_r;
      push_nxt = push_r;
      pop_nxt = pop_r;
      sp_nxt = sp_r;
      // Operands and state stay frozen while an instruction is running.
      if (wr_go && !busy_r && !go_r) begin
         case (aw_addr_r)
            `ADDR_CTRL: begin
               if (w_strb_r[0]) begin
                  op_nxt = op_e'(w_data_r[4:0]);
               end
               go_nxt = w_strb_r[1] && w_data_r[`CTRL_START];
            end
            `ADDR_OPND: opnd_nxt = merge(opnd_r, w_data_r, w_strb_r);
            `ADDR_OFFS: offs_nxt = 12'(merge(32'(offs_r), w_data_r,
                                             w_strb_r));
            `ADDR_ZPTR: zptr_nxt = 16'(merge(32'(zptr_r), w_data_r,
                                             w_strb_r));
            `ADDR_IOV: iov_nxt = 9'(merge(32'(iov_r), w_data_r, w_strb_r));
            `ADDR_PC: pc_nxt = PC_W'(merge(32'(pc_r), w_data_r, w_strb_r));
            `ADDR_FLAGS: begin
               if (w_strb_r[0]) begin
                  flags_nxt = wmerged[7:0];
               end
            end
            default: begin
               go_nxt = 1'b0;
            end
         endcase
      end
      if (go_r) begin
         busy_nxt = 1'b1;
         cnt_nxt = e_cyc;
         cyc_nxt = e_cyc;
         taken_nxt = e_hit;
         ppc_nxt = e_pc;
         pfl_nxt = e_fl;
         pres_nxt = e_res;
         push_nxt = (op_r == pointer_call_op);
         pop_nxt = (op_r == interrupt_return_op);
      end else if (busy_r) begin
         cnt_nxt = cnt_r - 3'h1;
      end
      if (commit) begin
         busy_nxt = 1'b0;
         pc_nxt = ppc_r;
         flags_nxt = pfl_r;
         res_nxt = pres_r;
         if (push_r) begin
            sp_nxt = sp_r + SP_W'(1);
         end else if (pop_r) begin
            sp_nxt = sp_r - SP_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (commit && push_r) begin
         stack_r[sp_r] <= pc_inc;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_rdy_r <= 1'b1;
         w_rdy_r <= 1'b1;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
         ar_rdy_r <= 1'b1;
         rvalid_r <= 1'b0;
         rresp_r <= `RESP_OKAY;
         rdata_r <= 32'h0000_0000;
         op_r <= no_op;
         go_r <= 1'b0;
         opnd_r <= 32'h0000_0000;
         offs_r <= 12'h000;
         zptr_r <= 16'h0000;
         iov_r <= 9'h000;
         pc_r <= '0;
         flags_r <= `BYTE_00;
         busy_r <= 1'b0;
         cnt_r <= 3'h0;
         cyc_r <= 3'h0;
         taken_r <= 1'b0;
         res_r <= `BYTE_00;
         ppc_r <= '0;
         pfl_r <= `BYTE_00;
         pres_r <= `BYTE_00;
         push_r <= 1'b0;
         pop_r <= 1'b0;
         sp_r <= '0;
      end else begin
         aw_rdy_r <= aw_rdy_nxt;
         w_rdy_r <= w_rdy_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         ar_rdy_r <= ar_rdy_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         op_r <= op_nxt;
         go_r <= go_nxt;
         opnd_r <= opnd_nxt;
         offs_r <= offs_nxt;
         zptr_r <= zptr_nxt;
         iov_r <= iov_nxt;
         pc_r <= pc_nxt;
         flags_r <= flags_nxt;
         busy_r <= busy_nxt;
         cnt_r <= cnt_nxt;
         cyc_r <= cyc_nxt;
         taken_r <= taken_nxt;
         res_r <= res_nxt;
         ppc_r <= ppc_nxt;
         pfl_r <= pfl_nxt;
         pres_r <= pres_nxt;
         push_r <= push_nxt;
         pop_r <= pop_nxt;
         sp_r <= sp_nxt;
      end
   end
endmodule

// file: include/alu_exec_defines.svh
`ifndef ALU_EXEC_DEFINES_SVH
`define ALU_EXEC_DEFINES_SVH
`define ADDR_CTRL 8'h00
`define ADDR_OPND 8'h04
`define ADDR_OFFS 8'h08
`define ADDR_ZPTR 8'h0C
`define ADDR_IOV 8'h10
`define ADDR_PC 8'h14
`define ADDR_FLAGS 8'h18
`define ADDR_STAT 8'h1C
`define CTRL_START 8
`define IOV_TWO_WORD 8
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_I 7
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4
`define CYC_FIVE 3'h5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BYTE_FF 8'hFF
`define BYTE_00 8'h00
`define BYTE_MIN 8'h80
`define SHORT_PC_W 16
`define SHORT_OFFS_W 7
`endif

// file: include/alu_exec_pkg.sv
package alu_exec_pkg;
   typedef enum logic [4:0] {
      no_op,
      ones_complement_op,
      twos_complement_op,
      set_bits_mask_op,
      clear_bits_mask_op,
      zero_minus_test_op,
      relative_jump_op,
      pointer_jump_op,
      pointer_call_op,
      interrupt_return_op,
      compare_skip_equal_op,
      skip_reg_bit_clear_op,
      skip_reg_bit_set_op,
      skip_io_bit_clear_op,
      skip_io_bit_set_op,
      branch_status_bit_set_op,
      branch_status_bit_clear_op,
      branch_carry_clear_op,
      branch_same_higher_op,
      branch_signed_not_less_op,
      branch_signed_less_op,
      branch_half_carry_set_op
   } op_e;
endpackage

// file: testbench/alu_exec_checker.sv
`timescale 1ns/1ns
`include "alu_exec_defines.svh"
module alu_exec_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   write_answer_a: assert property (
      awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write response not two cycles after address and data");
   b_release_a: assert property ($fell(bvalid) |-> $past(bready))
      else $error("write response dropped without bready");
   b_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write channels open while response pending");
   b_reopen_a: assert property (bvalid && bready |=> awready && wready)
      else $error("write channels not reopened after response");
   read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read data not one cycle after address");
   r_release_a: assert property ($fell(rvalid) |-> $past(rready))
      else $error("read data dropped without rready");
   bad_read_a: assert property (arvalid && arready && araddr > `ADDR_STAT
      |=> rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   good_read_a: assert property (arvalid && arready && araddr[1:0] == 2'h0
      && araddr <= `ADDR_STAT |=> rresp == `RESP_OKAY)
      else $error("mapped read refused");
endmodule

bind branch_skip_unary_alu_exec alu_exec_checker #(.ADDR_W(ADDR_W)) chk_i (
   .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
   .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
);

// file: testbench/branch_skip_unary_alu_exec_test.sv
`timescale 1ns/1ns
`include "alu_exec_defines.svh"
module branch_skip_unary_alu_exec_test
   import alu_exec_pkg::*;
;
   localparam logic [21:0] p = 22'h2F_0100;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, f;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata, st, v, b;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   int err_total, n_checks;

   branch_skip_unary_alu_exec uut (
      .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   // Each channel is released only at the edge that takes it; the extra
   // edge at the end keeps bready from being driven twice in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic run(input op_e op, input logic [31:0] opnd, offs, iov,
      input logic [7:0] fi, input logic [21:0] epc, input logic [7:0] ef,
      input logic [2:0] ec, input logic [8:0] eres);
      int n;
      wr(`ADDR_PC, p);
      wr(`ADDR_OPND, opnd);
      wr(`ADDR_OFFS, offs);
      wr(`ADDR_IOV, iov);
      wr(`ADDR_FLAGS, fi);
      wr(`ADDR_ZPTR, 16'hBEEF);
      wr(`ADDR_CTRL, {23'h0, 1'b1, 3'h0, op}, 4'h3);
      n = 0;
      do begin
         rd(`ADDR_STAT);
         n++;
      end while (v[0] !== 1'b0 && n < 40);
      st = v;
      chk("busy", '0, st[0]);
      chk("cycles", ec, st[4:2]);
      if (eres[8]) chk("result", eres[7:0], st[15:8]);
      if (op >= compare_skip_equal_op) chk("taken", ec > 1, st[1]);
      rd(`ADDR_PC);
      chk("pc", epc, v);
      rd(`ADDR_FLAGS);
      chk("flags", ef, v);
   endtask

   initial begin
      #400000;
      err_total++;
      end_of_test();
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
      err_total = 0;
      n_checks = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`ADDR_PC);
      chk("pc reset", '0, v);
      rd(`ADDR_FLAGS);
      chk("flags reset", '0, v);
      rd(8'h20);
      chk("bad read resp", `RESP_SLVERR, r);
      chk("bad read data", '0, v);
      rd(8'h02);
      chk("unaligned resp", `RESP_SLVERR, r);
      wr(8'h24, 32'h0000_0001);
      chk("bad write resp", `RESP_SLVERR, r);
      wr(`ADDR_STAT, 32'h0000_00FF);
      rd(`ADDR_STAT);
      chk("status read only", '0, v);
      run(set_bits_mask_op, 16'h8241, '0, '0, 8'h21, p+1, 8'h35, 1, 9'h1C3);
      run(clear_bits_mask_op, 16'hF0F0, '0, '0, 8'h0C, p+1, 8'h02, 1, 9'h100);
      run(zero_minus_test_op, 16'h0080, '0, '0, 8'h08, p+1, 8'h14, 1, 9'h180);
      run(ones_complement_op, 16'h000F, '0, '0, 8'h00, p+1, 8'h15, 1, 9'h1F0);
      run(twos_complement_op, 16'h0080, '0, '0, 8'h00, p+1, 8'h0D, 1, 9'h180);
      run(twos_complement_op, 16'h0000, '0, '0, 8'h20, p+1, 8'h02, 1, 9'h100);
      run(compare_skip_equal_op, 16'h5A5A, '0, '0, 8'h3F, p+2, 8'h3F, 2, '0);
      run(compare_skip_equal_op, 16'h5A5A, '0, 9'h100, 8'h3F, p+3, 8'h3F, 3, '0);
      run(compare_skip_equal_op, 16'h5A5B, '0, 9'h100, 8'h3F, p+1, 8'h3F, 1, '0);
      run(skip_reg_bit_clear_op, 20'h2_00FB, '0, '0, '0, p+2, '0, 2, '0);
      run(skip_reg_bit_clear_op, 20'h0_00FB, '0, 9'h100, '0, p+1, '0, 1, '0);
      run(skip_reg_bit_set_op, 20'h2_0004, '0, 9'h100, 8'hFF, p+3, 8'hFF, 3, '0);
      run(skip_reg_bit_set_op, 20'h2_00FB, '0, '0, 8'hFF, p+1, 8'hFF, 1, '0);
      run(skip_io_bit_clear_op, 20'h4_0000, '0, 9'h1EF, '0, p+3, '0, 3, '0);
      run(skip_io_bit_clear_op, 20'h4_0000, '0, 9'h010, '0, p+1, '0, 1, '0);
      run(skip_io_bit_set_op, 20'h4_0000, '0, 9'h010, '0, p+2, '0, 2, '0);
      run(skip_io_bit_set_op, 20'h3_0000, '0, 9'h010, '0, p+1, '0, 1, '0);
      // Offset 0x840 tells a 7-bit branch offset (-64) from a 12-bit one.
      for (int s = 0; s < 8; s++) begin
         f = 8'h01 << s;
         b = {13'h0, s[2:0], 16'h0};
         run(branch_status_bit_set_op, b, 12'h840, '0, f, p-63, f, 2, '0);
         run(branch_status_bit_set_op, b, 12'h840, '0, ~f, p+1, ~f, 1, '0);
         run(branch_status_bit_clear_op, b, 12'h840, '0, ~f, p-63, ~f, 2, '0);
         run(branch_status_bit_clear_op, b, 12'h840, '0, f, p+1, f, 1, '0);
      end
      run(branch_carry_clear_op, '0, 12'h840, '0, 8'hFE, p-63, 8'hFE, 2, '0);
      run(branch_carry_clear_op, '0, 12'h840, '0, 8'h01, p+1, 8'h01, 1, '0);
      run(branch_same_higher_op, '0, 12'h840, '0, 8'hFE, p-63, 8'hFE, 2, '0);
      run(branch_same_higher_op, '0, 12'h840, '0, 8'h01, p+1, 8'h01, 1, '0);
      run(branch_signed_not_less_op, '0, 12'h840, '0, 8'h0C, p-63, 8'h0C, 2, '0);
      run(branch_signed_not_less_op, '0, 12'h840, '0, 8'h04, p+1, 8'h04, 1, '0);
      run(branch_signed_less_op, '0, 12'h840, '0, 8'h08, p-63, 8'h08, 2, '0);
      run(branch_signed_less_op, '0, 12'h840, '0, 8'h0C, p+1, 8'h0C, 1, '0);
      run(branch_half_carry_set_op, '0, 12'h840, '0, 8'h20, p-63, 8'h20, 2, '0);
      run(branch_half_carry_set_op, '0, 12'h840, '0, 8'hDF, p+1, 8'hDF, 1, '0);
      run(relative_jump_op, '0, 12'h7FF, '0, 8'h5A, p+2048, 8'h5A, 2, '0);
      run(relative_jump_op, '0, 12'h800, '0, 8'h5A, p-2047, 8'h5A, 2, '0);
      run(pointer_jump_op, '0, '0, '0, 8'h5A, 22'h00_BEEF, 8'h5A, 2, '0);
      run(pointer_call_op, '0, '0, '0, 8'h41, 22'h00_BEEF, 8'h41, 4, '0);
      chk("stack after call", 8'h01, st[23:16]);
      run(interrupt_return_op, '0, '0, '0, 8'h01, p+1, 8'h81, 5, '0);
      chk("stack after return", 8'h00, st[23:16]);
      run(no_op, '0, '0, '0, 8'h5A, p+1, 8'h5A, 1, '0);
      // A write that lands while an instruction runs must be dropped.
      wr(`ADDR_OPND, 16'h0012);
      chk("write resp", `RESP_OKAY, r);
      wr(`ADDR_OPND, 32'h0000_5634, 4'h2);
      wr(`ADDR_CTRL, {23'h0, 1'b1, 3'h0, interrupt_return_op}, 4'h3);
      wr(`ADDR_OPND, 16'h0034);
      rd(`ADDR_OPND);
      chk("operand kept", 32'h0000_5612, v);
      rd(`ADDR_CTRL);
      chk("opcode", 32'(interrupt_return_op), v);
      end_of_test();
   end
endmodule
